// File: mpio_pkg.sv
// Package with register indexes, reset values and field positions for the port block
package mpio_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_P2_DIR   = 8'h00_C1;
    localparam logic [7:0] IDX_P2_LATCH = 8'h00_C3;
    localparam logic [7:0] IDX_P5_DIR   = 8'h00_C8;
    localparam logic [7:0] IDX_P5_LATCH = 8'h00_CA;
    localparam logic [7:0] IDX_P8_DIR   = 8'h00_CD;
    localparam logic [7:0] IDX_P7_PINS  = 8'h00_CE;
    localparam logic [7:0] IDX_P8_LATCH = 8'h00_CF;
    localparam logic [7:0] IDX_PA_DIR   = 8'h00_D1;
    localparam logic [7:0] IDX_PA_LATCH = 8'h00_D3;
    localparam logic [7:0] IDX_PB_DIR   = 8'h00_D4;
    localparam logic [7:0] IDX_PB_LATCH = 8'h00_D6;
    localparam logic [7:0] IDX_P2_PULL  = 8'h00_D8;
    localparam logic [7:0] IDX_P5_PULL  = 8'h00_DB;
    // Field positions
    localparam int IDX_LSB  = 2;
    localparam int IDX_MSB  = 9;
    localparam int ADR_HI   = 10;
    // Reset values
    localparam logic [7:0] RST_BYTE     = 8'h00_00;
    localparam logic [3:0] RST_NIBBLE   = 4'h0;
    localparam logic [4:0] RST_P8       = 5'h00;
    // Fixed read values of unimplemented bits, write-only registers and unmapped indexes
    localparam logic [3:0] P5_FILL      = 4'hF;
    localparam logic [2:0] P8_FILL      = 3'h7;
    localparam logic [7:0] WO_READ      = 8'h00_FF;
    localparam logic [7:0] BAD_READ     = 8'h00_00;
    // Total count of pins that pass the synchroniser
    localparam int NPINS = 41;
endpackage

// File: mpio_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back
`timescale 1ns/100ps
interface mpio_sync_if;
    import mpio_pkg::*;
    logic [NPINS-1:0] raw;
    logic [NPINS-1:0] level;
    modport core (output raw, input level);
    modport sync (input raw, output level);
endinterface

// File: mpio_pin_sync.sv
// Two-stage synchroniser for all port pin inputs
`timescale 1ns/100ps
module mpio_pin_sync
    import mpio_pkg::*;
(
    input wire logic   mclk,
    input wire logic   reset,
    mpio_sync_if.sync  sif
);
    logic [NPINS-1:0] stage1;
    logic [NPINS-1:0] stage2;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= sif.raw;
            stage2 <= stage1;
        end
    end

    assign sif.level = stage2;
endmodule

// File: mpio_ports.sv
// Port register file with Wishbone slave, pin drivers and pull-up control
// Functional notes
// - Direction bit 0 makes the pin an input, 1 makes it an output.
// - Port 7 data is read-only and returns sampled pin levels.
// - Port 8 data has five read/write bits reset to 0; top three read 1.
// - Port B data read/write, direction write-only, both at own addresses, reset 0.
// - Port 2 pull-up bit enables pull-up only while its direction bit is 0.
// - Port 5 pull-up has four low bits, top four read 1, input-only.
`timescale 1ns/100ps
module mpio_ports
    import mpio_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  p2_in,
    output logic      [7:0]  p2_out,
    output logic      [7:0]  p2_oe_n,
    output logic      [7:0]  p2_pullup,
    input  wire logic [3:0]  p5_in,
    output logic      [3:0]  p5_out,
    output logic      [3:0]  p5_oe_n,
    output logic      [3:0]  p5_pullup,
    input  wire logic [7:0]  p7_in,
    input  wire logic [4:0]  p8_in,
    output logic      [4:0]  p8_out,
    output logic      [4:0]  p8_oe_n,
    input  wire logic [7:0]  pa_in,
    output logic      [7:0]  pa_out,
    output logic      [7:0]  pa_oe_n,
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe_n
);
    mpio_sync_if sif ();

    logic [7:0] port_2_direction;
    logic [7:0] port_2_output_latch;
    logic [7:0] port_2_pullup_enable;
    logic [3:0] port_5_direction;
    logic [3:0] port_5_output_latch;
    logic [3:0] port_5_pullup_enable;
    logic [4:0] port_8_direction;
    logic [4:0] port_8_output_latch;
    logic [7:0] port_a_direction;
    logic [7:0] port_a_output_latch;
    logic [7:0] port_b_direction;
    logic [7:0] port_b_output_latch;
    logic [7:0] p2_lvl;
    logic [3:0] p5_lvl;
    logic [7:0] p7_lvl;
    logic [4:0] p8_lvl;
    logic [7:0] pa_lvl;
    logic [7:0] pb_lvl;
    logic       req;
    logic       wr_go;
    logic       hi_zero;
    logic [7:0] idx;
    logic [7:0] next_rdata;
    logic [7:0] p5_mix;

    // Per-bit data read: latch when output, pin when input
    function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pins);
        mix_read = (dir & latch) | (~dir & pins);
    endfunction

    // Port 5 data read widened to a byte for the shared mixer
    assign p5_mix = mix_read({4'h0, port_5_direction}, {4'h0, port_5_output_latch},
                             {4'h0, p5_lvl});

    // Pin synchroniser
    assign sif.raw = {pb_in, pa_in, p8_in, p7_in, p5_in, p2_in};
    assign {pb_lvl, pa_lvl, p8_lvl, p7_lvl, p5_lvl, p2_lvl} = sif.level;

    mpio_pin_sync u_sync (
        .mclk  (mclk),
        .reset (reset),
        .sif   (sif)
    );

    // Bus decode
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_go   = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign idx     = wb_adr_i[IDX_MSB:IDX_LSB];
    assign hi_zero = (wb_adr_i[31:ADR_HI] == '0);

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = BAD_READ;
        if (hi_zero) begin
            unique case (idx)
                IDX_P2_DIR:   next_rdata = WO_READ;
                IDX_P5_DIR:   next_rdata = WO_READ;
                IDX_P8_DIR:   next_rdata = WO_READ;
                IDX_PA_DIR:   next_rdata = WO_READ;
                IDX_PB_DIR:   next_rdata = WO_READ;
                IDX_P2_LATCH: next_rdata = mix_read(port_2_direction,
                                                    port_2_output_latch, p2_lvl);
                IDX_P5_LATCH: next_rdata = {P5_FILL, p5_mix[3:0]};
                IDX_P7_PINS:  next_rdata = p7_lvl;
                IDX_P8_LATCH: next_rdata = {P8_FILL, port_8_output_latch};
                IDX_PA_LATCH: next_rdata = mix_read(port_a_direction,
                                                    port_a_output_latch, pa_lvl);
                IDX_PB_LATCH: next_rdata = mix_read(port_b_direction,
                                                    port_b_output_latch, pb_lvl);
                IDX_P2_PULL:  next_rdata = port_2_pullup_enable;
                IDX_P5_PULL:  next_rdata = {P5_FILL, port_5_pullup_enable};
                default:      next_rdata = BAD_READ;
            endcase
        end
    end

    // Read data register, loaded on the request cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_dat_o <= '0;
        end else if (req & ~wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, next_rdata};
        end
    end

    // Port 2 registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_2_direction     <= RST_BYTE;
            port_2_output_latch  <= RST_BYTE;
            port_2_pullup_enable <= RST_BYTE;
        end else if (wr_go & hi_zero) begin
            if (idx == IDX_P2_DIR)   port_2_direction     <= wb_dat_i[7:0];
            if (idx == IDX_P2_LATCH) port_2_output_latch  <= wb_dat_i[7:0];
            if (idx == IDX_P2_PULL)  port_2_pullup_enable <= wb_dat_i[7:0];
        end
    end

    // Port 5 registers, low nibble only
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_5_direction     <= RST_NIBBLE;
            port_5_output_latch  <= RST_NIBBLE;
            port_5_pullup_enable <= RST_NIBBLE;
        end else if (wr_go & hi_zero) begin
            if (idx == IDX_P5_DIR)   port_5_direction     <= wb_dat_i[3:0];
            if (idx == IDX_P5_LATCH) port_5_output_latch  <= wb_dat_i[3:0];
            if (idx == IDX_P5_PULL)  port_5_pullup_enable <= wb_dat_i[3:0];
        end
    end

    // Port 8 registers, low five bits only
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_8_direction    <= RST_P8;
            port_8_output_latch <= RST_P8;
        end else if (wr_go & hi_zero) begin
            if (idx == IDX_P8_DIR)   port_8_direction    <= wb_dat_i[4:0];
            if (idx == IDX_P8_LATCH) port_8_output_latch <= wb_dat_i[4:0];
        end
    end

    // Port A and port B registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_a_direction    <= RST_BYTE;
            port_a_output_latch <= RST_BYTE;
            port_b_direction    <= RST_BYTE;
            port_b_output_latch <= RST_BYTE;
        end else if (wr_go & hi_zero) begin
            if (idx == IDX_PA_DIR)   port_a_direction    <= wb_dat_i[7:0];
            if (idx == IDX_PA_LATCH) port_a_output_latch <= wb_dat_i[7:0];
            if (idx == IDX_PB_DIR)   port_b_direction    <= wb_dat_i[7:0];
            if (idx == IDX_PB_LATCH) port_b_output_latch <= wb_dat_i[7:0];
        end
    end

    // Pin drivers: enable low while driving
    assign p2_out  = port_2_output_latch;
    assign p2_oe_n = ~port_2_direction;
    assign p5_out  = port_5_output_latch;
    assign p5_oe_n = ~port_5_direction;
    assign p8_out  = port_8_output_latch;
    assign p8_oe_n = ~port_8_direction;
    assign pa_out  = port_a_output_latch;
    assign pa_oe_n = ~port_a_direction;
    assign pb_out  = port_b_output_latch;
    assign pb_oe_n = ~port_b_direction;

    // Pull-ups only on input pins
    assign p2_pullup = port_2_pullup_enable & ~port_2_direction;
    assign p5_pullup = port_5_pullup_enable & ~port_5_direction;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_timing_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    dir_oe_a: assert property (pb_oe_n == ~port_b_direction)
        else $error("port b enable mismatch");
    p7_read_a: assert property (req && !wb_ack_o && hi_zero && idx == IDX_P7_PINS
                                |=> wb_dat_o[7:0] == $past(p7_lvl))
        else $error("port 7 read not pin level");
    p8_fill_a: assert property (req && !wb_ack_o && hi_zero && idx == IDX_P8_LATCH
                                |=> wb_dat_o[7:5] == 3'h7)
        else $error("port 8 upper bits not one");
    pa_write_a: assert property (wr_go && hi_zero && idx == IDX_PA_LATCH
                                 |=> pa_out == $past(wb_dat_i[7:0]))
        else $error("port a write lost");
    pb_dir_read_a: assert property (req && !wb_ack_o && hi_zero && idx == IDX_PB_DIR
                                    |=> wb_dat_o[7:0] == 8'hFF)
        else $error("port b direction readable");
    p2_pull_a: assert property (port_2_direction[0] |-> !p2_pullup[0])
        else $error("pull-up on output pin");
    p5_pull_a: assert property (p5_pullup == (port_5_pullup_enable & ~port_5_direction))
        else $error("port 5 pull-up mismatch");
    mix_out_a: assert property (req && !wb_ack_o && hi_zero && idx == IDX_PB_LATCH
                                && port_b_direction == 8'hFF
                                |=> wb_dat_o[7:0] == $past(port_b_output_latch))
        else $error("output readback not latch");

    pb_write_c: cover property (wr_go && idx == IDX_PB_LATCH);
    p7_read_c: cover property (req && !wb_ack_o && idx == IDX_P7_PINS && !wb_we_i);
    pull_on_c: cover property (p2_pullup != 8'h00);
endmodule

// File: mpio_board.sv
// Board model driving the port pins from the drive input level, pin drivers and pull-ups
`timescale 1ns/100ps
module mpio_board
    import mpio_pkg::*;
(
    input  wire logic [7:0] drive,
    input  wire logic [7:0] p2_out,
    input  wire logic [7:0] p2_oe_n,
    input  wire logic [7:0] p2_pullup,
    input  wire logic [3:0] p5_out,
    input  wire logic [3:0] p5_oe_n,
    input  wire logic [3:0] p5_pullup,
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe_n,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    output logic      [7:0] p2_in,
    output logic      [3:0] p5_in,
    output logic      [7:0] p7_in,
    output logic      [4:0] p8_in,
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in
);
    // Driven pins of ports 2, 5, A and B follow the latch, others the board level or the pull-up
    assign p2_in = (p2_out & ~p2_oe_n) | ((drive | p2_pullup) & p2_oe_n);
    assign p5_in = (p5_out & ~p5_oe_n) | ((drive[3:0] | p5_pullup) & p5_oe_n);
    assign pa_in = (pa_out & ~pa_oe_n) | (drive & pa_oe_n);
    assign pb_in = (pb_out & ~pb_oe_n) | (drive & pb_oe_n);
    assign p7_in = drive;
    assign p8_in = drive[4:0];
endmodule

// File: test_multi_port_pin_io_regs.sv
// Self-checking bench for the port register block
`timescale 1ns/100ps
module test_multi_port_pin_io_regs;
    import mpio_pkg::*;
    typedef struct packed {
        logic [7:0] widx;
        logic [7:0] wd;
        logic       s0;
        logic [7:0] ridx;
        logic [7:0] exp;
    } mpio_row_t;
    logic mclk = 1'b0, reset = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0000_0000, wb_dat = 32'h0000_0000, wb_dat_o;
    logic [3:0] wb_sel = 4'h0, p5_in, p5_out, p5_oe_n, p5_pullup;
    logic [7:0] drive = 8'h24, p2_in, p2_out, p2_oe_n, p2_pullup, p7_in, pa_in, pa_out;
    logic [7:0] pa_oe_n, pb_in, pb_out, pb_oe_n, q;
    logic [4:0] p8_in, p8_out, p8_oe_n;
    logic wb_ack_o;
    int err_count = 0, total_checks = 0;
    mpio_row_t rows [17] = '{
        '{IDX_PB_DIR, 8'h00, 1'b1, IDX_PB_DIR, 8'hFF},
        '{IDX_PB_DIR, 8'hFF, 1'b1, IDX_PB_DIR, 8'hFF},
        '{IDX_PB_LATCH, 8'h5A, 1'b1, IDX_PB_LATCH, 8'h5A},
        '{IDX_PB_LATCH, 8'hA5, 1'b0, IDX_PB_LATCH, 8'h5A},
        '{IDX_PA_LATCH, 8'h3C, 1'b1, IDX_PA_LATCH, 8'h24},
        '{IDX_PA_DIR, 8'h0F, 1'b1, IDX_PA_LATCH, 8'h2C},
        '{IDX_P8_LATCH, 8'hFF, 1'b1, IDX_P8_LATCH, 8'hFF},
        '{IDX_P8_LATCH, 8'h00, 1'b1, IDX_P8_LATCH, 8'hE0},
        '{IDX_P8_DIR, 8'h1F, 1'b1, IDX_P8_DIR, 8'hFF},
        '{IDX_P7_PINS, 8'h00, 1'b1, IDX_P7_PINS, 8'h24},
        '{IDX_P2_PULL, 8'h81, 1'b1, IDX_P2_PULL, 8'h81},
        '{IDX_P2_DIR, 8'h01, 1'b1, IDX_P2_LATCH, 8'hA4},
        '{IDX_P2_LATCH, 8'h5B, 1'b1, IDX_P2_LATCH, 8'hA5},
        '{IDX_P5_PULL, 8'hFF, 1'b1, IDX_P5_PULL, 8'hFF},
        '{IDX_P5_DIR, 8'h01, 1'b1, IDX_P5_LATCH, 8'hFE},
        '{IDX_P5_LATCH, 8'h03, 1'b1, IDX_P5_LATCH, 8'hFF},
        '{8'hFF, 8'h12, 1'b1, 8'hFF, 8'h00}
    };
    mpio_ports u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .p2_in(p2_in), .p2_out(p2_out),
        .p2_oe_n(p2_oe_n), .p2_pullup(p2_pullup), .p5_in(p5_in), .p5_out(p5_out),
        .p5_oe_n(p5_oe_n), .p5_pullup(p5_pullup), .p7_in(p7_in), .p8_in(p8_in),
        .p8_out(p8_out), .p8_oe_n(p8_oe_n), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n));
    mpio_board u_board (.drive(drive), .p2_out(p2_out), .p2_oe_n(p2_oe_n),
        .p2_pullup(p2_pullup), .p5_out(p5_out), .p5_oe_n(p5_oe_n), .p5_pullup(p5_pullup),
        .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
        .p2_in(p2_in), .p5_in(p5_in), .p7_in(p7_in), .p8_in(p8_in), .pa_in(pa_in),
        .pb_in(pb_in));
    // Clock of 8 ns period
    always #4 mclk = ~mclk;
    // Byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Classic Wishbone single cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [7:0] d,
                           input logic s0, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= {24'h00_0000, d};
        wb_sel <= {3'b000, s0};
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rd = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    // Watchdog
    initial begin
        #(8 * 4000);
        err_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            wb_xfer(1'b1, {22'h0, rows[i].widx, 2'b00}, rows[i].wd, rows[i].s0, q);
            wb_xfer(1'b0, {22'h0, rows[i].ridx, 2'b00}, 8'h00, 1'b1, q);
            chk8(q, rows[i].exp);
        end
        chk8(pb_out, 8'h5A);
        chk8(pb_oe_n, 8'h00);
        chk8(pa_oe_n, 8'hF0);
        chk8(p2_pullup, 8'h80);
        chk8({4'h0, p5_pullup}, 8'h0E);
        chk8(p2_out, 8'h5B);
        chk8({4'h0, p5_out}, 8'h03);
        chk8({4'h0, p5_oe_n}, 8'h0E);
        chk8({3'h0, p8_oe_n}, 8'h00);
        chk8({3'h0, p8_out}, 8'h00);
        // Pin change seen through the port 7 input, after the two sync stages
        drive <= 8'h5A;
        repeat (2) @(posedge mclk);
        wb_xfer(1'b0, {22'h0, IDX_P7_PINS, 2'b00}, 8'h00, 1'b1, q);
        chk8(q, 8'h5A);
        // Upper address bit set leaves port A untouched
        wb_xfer(1'b1, {22'h1, IDX_PA_LATCH, 2'b00}, 8'hFF, 1'b1, q);
        wb_xfer(1'b0, {22'h0, IDX_PA_LATCH, 2'b00}, 8'h00, 1'b1, q);
        chk8(q, 8'h5C);
        chk8(pa_out, 8'h3C);
        // Reset in mid-run
        @(posedge mclk);
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk8(pa_out, 8'h00);
        chk8(pa_oe_n & pb_oe_n & p2_oe_n, 8'hFF);
        chk8({3'h0, p8_oe_n}, 8'h1F);
        chk8(p2_pullup, 8'h00);
        wb_xfer(1'b0, {22'h0, IDX_P8_LATCH, 2'b00}, 8'h00, 1'b1, q);
        chk8(q, 8'hE0);
        wb_xfer(1'b0, {22'h0, IDX_P5_PULL, 2'b00}, 8'h00, 1'b1, q);
        chk8(q, 8'hF0);
        wb_xfer(1'b0, {22'h0, IDX_PB_LATCH, 2'b00}, 8'h00, 1'b1, q);
        chk8(q, 8'h5A);
        report_and_stop();
    end
endmodule
